// [include/fhp_consts.svh]
// Constants of the floating point coprocessor host port: offsets, fields, counts.
`ifndef FHP_CONSTS_SVH
`define FHP_CONSTS_SVH

// ==========================================================================
// Clock and timing.
`define FHP_CLK_PERIOD_NS      25
`define FHP_RESET_MIN_CLKS     5
`define FHP_SYNC_STAGES        2

// ==========================================================================
// Bus and command layout.
`define FHP_DATA_W             8
`define FHP_OP_W               7
`define FHP_CMD_SVC_BIT        7
`define FHP_STACK_DEPTH        32

// ==========================================================================
// Status byte layout and reset value.
`define FHP_STAT_BUSY_BIT      7
`define FHP_STAT_ERR_LSB       0
`define FHP_ERR_W              3
`define FHP_STATUS_RESET       8'h00

`endif

// [include/fhp_pkg.sv]
// Types shared by the coprocessor host port modules.
package fhp_pkg;

	// ==========================================================================
	// Handshake states.
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WR_WAIT,
		ST_WR_ACK,
		ST_RD_WAIT,
		ST_RD_HOLD
	} fhp_state_e;

	// ==========================================================================
	// Host-facing control inputs, all asynchronous to the clock.
	typedef struct packed {
		logic cs_n;
		logic cmd_sel;
		logic rd_n;
		logic wr_n;
		logic done_ack_n;
		logic svc_ack_n;
	} fhp_ctl_s;

	typedef logic [7:0] fhp_byte_t;

endpackage

// [core/fhp_sync.sv]
// Two-stage synchroniser bank for the host control inputs.
`timescale 1ns/1ps
module fhp_sync #(
	parameter int              WIDTH     = 6,
	parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
	input  wire logic             clk_i,   // System clock.
	input  wire logic             rst_i,   // Asynchronous reset, active high.
	input  wire logic [WIDTH-1:0] async_i, // Raw inputs.
	output logic      [WIDTH-1:0] sync_o   // Synchronised levels.
);

	// ==========================================================================
	// One pair of flops per bit; only the second stage is ever read.
	genvar g;
	generate
		for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
			logic meta_reg;
			logic meta_next;
			logic hold_reg;
			logic hold_next;

			// Next values simply shift the input along.
			always_comb begin
				meta_next = async_i[g];
				hold_next = meta_reg;
			end

			// Both stages return to the idle level of the pin under reset.
			always_ff @(posedge clk_i or posedge rst_i) begin
				if (rst_i) begin
					meta_reg <= RESET_VAL[g];
					hold_reg <= RESET_VAL[g];
				end else begin
					meta_reg <= meta_next;
					hold_reg <= hold_next;
				end
			end

			assign sync_o[g] = hold_reg;
		end
	endgenerate

endmodule

// [core/fhp_byte_stack.sv]
// Byte-wide last-in first-out operand store held in flip-flops.
`timescale 1ns/1ps
module fhp_byte_stack #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input  wire logic             clk_i,  // System clock.
	input  wire logic             rst_i,  // Asynchronous reset, active high.
	input  wire logic             push_i, // Store din_i above the top.
	input  wire logic             pop_i,  // Drop the top entry.
	input  wire logic [WIDTH-1:0] din_i,  // Byte to push.
	output logic      [WIDTH-1:0] top_o   // Current top entry.
);

	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [WIDTH-1:0] mem_next [DEPTH];
	logic [PW-1:0]    ptr_reg;
	logic [PW-1:0]    ptr_next;
	logic [PW-1:0]    top_idx;

	// Pointer wraps silently, so a wrong byte count skews later operands.
	always_comb begin
		top_idx  = ptr_reg - PW'(1);
		ptr_next = ptr_reg;
		for (int i = 0; i < DEPTH; i++) begin
			mem_next[i] = mem_reg[i];
		end
		if (push_i) begin
			mem_next[ptr_reg] = din_i;
			ptr_next          = ptr_reg + PW'(1);
		end else if (pop_i) begin
			ptr_next = top_idx;
		end
	end

	// Reset only reinitialises the pointer; contents are left as they are.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ptr_reg <= '0;
		end else begin
			ptr_reg <= ptr_next;
		end
	end

	// The storage needs no reset value.
	always_ff @(posedge clk_i) begin
		for (int i = 0; i < DEPTH; i++) begin
			mem_reg[i] <= mem_next[i];
		end
	end

	assign top_o = mem_reg[top_idx];

endmodule

// [core/fhp_host_port.sv]
// Host port of the floating point coprocessor: handshake, flags and operand bytes.
`timescale 1ns/1ps
`include "fhp_consts.svh"
module fhp_host_port
	import fhp_pkg::*;
#(
	parameter int STACK_DEPTH = `FHP_STACK_DEPTH
) (
	input  wire logic                     SYS_CLK_I,         // 40 MHz system clock.
	input  wire logic                     RST_I,             // Asynchronous reset, high.
	input  wire logic                     CS_N_I,            // Chip select, low.
	input  wire logic                     CMD_SEL_I,         // High command, low data.
	input  wire logic                     RD_N_I,            // Read strobe, low.
	input  wire logic                     WR_N_I,            // Write strobe, low.
	input  wire logic [`FHP_DATA_W-1:0]   DATA_LINES_I,      // Data bus in.
	output logic      [`FHP_DATA_W-1:0]   DATA_LINES_O,      // Data bus out.
	output logic                          DATA_LINES_OE_O,   // High while driving bus.
	output logic                          WAIT_N_O,          // Low stretches access.
	output logic                          DONE_O,            // Command complete.
	input  wire logic                     DONE_ACK_N_I,      // Clears done, low.
	output logic                          SERVICE_REQUEST_O, // Service request.
	input  wire logic                     SERVICE_ACK_N_I,   // Clears service, low.
	output logic                          FAULT_O,           // Arithmetic error.
	output logic                          EXEC_START_O,      // One-cycle command pulse.
	output logic      [`FHP_OP_W-1:0]     EXEC_OP_O,         // Operation code.
	output logic                          EXEC_ABORT_O,      // Abort to datapath.
	input  wire logic                     EXEC_DONE_I,       // Datapath finished pulse.
	input  wire logic [`FHP_ERR_W-1:0]    EXEC_ERR_I         // Error bit set pulses.
);

	// ==========================================================================
	// Synchronised control inputs.
	fhp_ctl_s ctl_raw;
	fhp_ctl_s ctl_sync;
	fhp_ctl_s ctl_prev_reg;
	fhp_ctl_s ctl_prev_next;

	assign ctl_raw = '{cs_n: CS_N_I, cmd_sel: CMD_SEL_I, rd_n: RD_N_I, wr_n: WR_N_I,
		done_ack_n: DONE_ACK_N_I, svc_ack_n: SERVICE_ACK_N_I};

	// All pins idle high except the command select, which idles low.
	fhp_sync #(
		.WIDTH     ($bits(fhp_ctl_s)),
		.RESET_VAL (6'h2f)
	) u_sync (
		.clk_i   (SYS_CLK_I),
		.rst_i   (RST_I),
		.async_i (ctl_raw),
		.sync_o  (ctl_sync)
	);

	// Previous synchronised levels give edge detection.
	always_comb begin
		ctl_prev_next = ctl_sync;
	end

	always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			ctl_prev_reg <= 6'h2f;
		end else begin
			ctl_prev_reg <= ctl_prev_next;
		end
	end

	logic wr_fall;
	logic rd_fall;
	logic selected;

	// Strobe edges count only while the chip is selected and the other strobe is idle.
	assign selected = ~ctl_sync.cs_n;
	assign wr_fall  = selected & ctl_prev_reg.wr_n & ~ctl_sync.wr_n & ctl_sync.rd_n;
	assign rd_fall  = selected & ctl_prev_reg.rd_n & ~ctl_sync.rd_n & ctl_sync.wr_n;

	// ==========================================================================
	// Operand stack.
	logic                   push;
	logic                   pop;
	logic [`FHP_DATA_W-1:0] stack_top;

	fhp_byte_stack #(
		.WIDTH (`FHP_DATA_W),
		.DEPTH (STACK_DEPTH)
	) u_stack (
		.clk_i  (SYS_CLK_I),
		.rst_i  (RST_I),
		.push_i (push),
		.pop_i  (pop),
		.din_i  (DATA_LINES_I),
		.top_o  (stack_top)
	);

	// ==========================================================================
	// Access handshake.
	fhp_state_e             state_reg;
	fhp_state_e             state_next;
	logic                   sel_reg;
	logic                   sel_next;
	logic                   wait_n_reg;
	logic                   wait_n_next;
	logic [`FHP_DATA_W-1:0] dout_reg;
	logic [`FHP_DATA_W-1:0] dout_next;
	logic                   oe_reg;
	logic                   oe_next;
	logic [`FHP_DATA_W-1:0] wdata_reg;
	logic [`FHP_DATA_W-1:0] wdata_next;
	logic                   cmd_write;
	logic                   status_read;
	logic                   access_clear;
	logic                   busy_reg;
	logic [`FHP_DATA_W-1:0] status_byte;

	// Only status reads pass a running command; every other access waits for it.
	always_comb begin
		state_next   = state_reg;
		sel_next     = sel_reg;
		wait_n_next  = wait_n_reg;
		dout_next    = dout_reg;
		oe_next      = oe_reg;
		wdata_next   = wdata_reg;
		push         = 1'b0;
		pop          = 1'b0;
		cmd_write    = 1'b0;
		status_read  = 1'b0;
		access_clear = 1'b0;
		case (state_reg)
			ST_IDLE: begin
				wait_n_next = ctl_sync.cs_n;
				oe_next     = 1'b0;
				if (wr_fall) begin
					sel_next    = ctl_sync.cmd_sel;
					wdata_next  = DATA_LINES_I;
					wait_n_next = 1'b0;
					state_next  = ST_WR_WAIT;
				end else if (rd_fall) begin
					sel_next     = ctl_sync.cmd_sel;
					access_clear = 1'b1;
					wait_n_next  = 1'b0;
					state_next   = ST_RD_WAIT;
				end
			end
			ST_WR_WAIT: begin
				if (!busy_reg) begin
					cmd_write   = sel_reg;
					push        = ~sel_reg;
					wait_n_next = 1'b1;
					state_next  = ST_WR_ACK;
				end
			end
			ST_WR_ACK: begin
				if (ctl_sync.wr_n) begin
					access_clear = 1'b1;
					wait_n_next  = ctl_sync.cs_n;
					state_next   = ST_IDLE;
				end
			end
			ST_RD_WAIT: begin
				if (sel_reg || !busy_reg) begin
					status_read = sel_reg;
					pop         = ~sel_reg;
					dout_next   = sel_reg ? status_byte : stack_top;
					oe_next     = 1'b1;
					wait_n_next = 1'b1;
					state_next  = ST_RD_HOLD;
				end
			end
			ST_RD_HOLD: begin
				if (ctl_sync.rd_n) begin
					oe_next     = 1'b0;
					wait_n_next = ctl_sync.cs_n;
					state_next  = ST_IDLE;
				end
			end
			default: begin
				oe_next     = 1'b0;
				wait_n_next = 1'b1;
				state_next  = ST_IDLE;
			end
		endcase
	end

	// The wait line resets high and idles at the chip select level, so a deselected idle port never holds the host.
	always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			state_reg  <= ST_IDLE;
			sel_reg    <= 1'b0;
			wait_n_reg <= 1'b1;
			dout_reg   <= '0;
			oe_reg     <= 1'b0;
			wdata_reg  <= '0;
		end else begin
			state_reg  <= state_next;
			sel_reg    <= sel_next;
			wait_n_reg <= wait_n_next;
			dout_reg   <= dout_next;
			oe_reg     <= oe_next;
			wdata_reg  <= wdata_next;
		end
	end

	// ==========================================================================
	// Command issue and status register.
	logic                   busy_next;
	logic                   svc_en_reg;
	logic                   svc_en_next;
	logic [`FHP_OP_W-1:0]   op_reg;
	logic [`FHP_OP_W-1:0]   op_next;
	logic                   start_reg;
	logic                   start_next;
	logic                   abort_reg;
	logic                   abort_next;
	logic [`FHP_ERR_W-1:0]  err_reg;
	logic [`FHP_ERR_W-1:0]  err_next;

	// Busy sits in the top status bit, the error bits at the bottom.
	always_comb begin
		status_byte = `FHP_STATUS_RESET;
		status_byte[`FHP_STAT_BUSY_BIT] = busy_reg;
		status_byte[`FHP_STAT_ERR_LSB +: `FHP_ERR_W] = err_reg;
	end

	// A new command clears old error bits; a datapath error set wins that cycle.
	always_comb begin
		busy_next   = busy_reg;
		svc_en_next = svc_en_reg;
		op_next     = op_reg;
		start_next  = 1'b0;
		abort_next  = 1'b0;
		err_next    = err_reg;
		if (cmd_write) begin
			op_next     = wdata_reg[`FHP_OP_W-1:0];
			svc_en_next = wdata_reg[`FHP_CMD_SVC_BIT];
			start_next  = 1'b1;
			busy_next   = 1'b1;
			err_next    = '0;
		end else if (EXEC_DONE_I) begin
			busy_next = 1'b0;
		end
		err_next = err_next | EXEC_ERR_I;
	end

	// Reset drops busy and errors and pulses abort so the datapath stops.
	always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			busy_reg   <= 1'b0;
			svc_en_reg <= 1'b0;
			op_reg     <= '0;
			start_reg  <= 1'b0;
			abort_reg  <= 1'b1;
			err_reg    <= '0;
		end else begin
			busy_reg   <= busy_next;
			svc_en_reg <= svc_en_next;
			op_reg     <= op_next;
			start_reg  <= start_next;
			abort_reg  <= abort_next;
			err_reg    <= err_next;
		end
	end

	// ==========================================================================
	// Completion, service and fault flags.
	logic done_reg;
	logic done_next;
	logic svc_reg;
	logic svc_next;
	logic fault_reg;
	logic fault_next;
	logic completion;

	assign completion = busy_reg & EXEC_DONE_I & ~cmd_write;

	// Setting beats clearing, so a tied-low acknowledge still gives one clock high.
	always_comb begin
		done_next  = done_reg;
		svc_next   = svc_reg;
		fault_next = fault_reg;
		if (!ctl_sync.done_ack_n || access_clear) begin
			done_next = 1'b0;
		end
		if (completion) begin
			done_next = 1'b1;
		end
		if (!ctl_sync.svc_ack_n) begin
			svc_next = 1'b0;
		end
		if (completion) begin
			svc_next = svc_en_reg;
		end
		if (status_read) begin
			fault_next = 1'b0;
		end
		if (|EXEC_ERR_I) begin
			fault_next = 1'b1;
		end
	end

	// All three flags come up low out of reset.
	always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			done_reg  <= 1'b0;
			svc_reg   <= 1'b0;
			fault_reg <= 1'b0;
		end else begin
			done_reg  <= done_next;
			svc_reg   <= svc_next;
			fault_reg <= fault_next;
		end
	end

	// ==========================================================================
	// Outputs, each straight from a flop.
	assign DATA_LINES_O      = dout_reg;
	assign DATA_LINES_OE_O   = oe_reg;
	assign WAIT_N_O          = wait_n_reg;
	assign DONE_O            = done_reg;
	assign SERVICE_REQUEST_O = svc_reg;
	assign FAULT_O           = fault_reg;
	assign EXEC_START_O      = start_reg;
	assign EXEC_OP_O         = op_reg;
	assign EXEC_ABORT_O      = abort_reg;

endmodule

// [tb/fhp_exec_model.sv]
// Behavioural model of the arithmetic datapath behind the host port.
`timescale 1ns/1ps
module fhp_exec_model (
	input  wire logic       clk_i,   // System clock.
	input  wire logic       rst_i,   // Asynchronous reset, active high.
	input  wire logic       start_i, // Command issue pulse.
	input  wire logic       abort_i, // Abort of a running command.
	input  wire logic [7:0] lat_i,   // Execution length in cycles, three or more.
	input  wire logic [2:0] err_i,   // Error bits to raise during the run.
	output logic            done_o,  // One-cycle finish pulse.
	output logic      [2:0] err_o    // One-cycle error set pulses.
);
	// ==========================================================================
	// Execution counter.
	logic [7:0] cnt_reg;
	logic [7:0] cnt_next;

	// Load on a start, count down, and forget everything on an abort.
	always_comb begin
		cnt_next = cnt_reg;
		if (abort_i) begin
			cnt_next = 8'h00;
		end else if (start_i) begin
			cnt_next = lat_i;
		end else if (cnt_reg != 8'h00) begin
			cnt_next = cnt_reg - 8'h01;
		end
	end

	// Registers only.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_reg <= 8'h00;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	// Errors land a cycle before the finish, so the fault leads completion.
	assign err_o  = (cnt_reg == 8'h02) ? err_i : 3'h0;
	assign done_o = (cnt_reg == 8'h01);
endmodule

// [tb/fhp_host_port_properties.sv]
// Concurrent checks on the pins of the host port.
`timescale 1ns/1ps
module fhp_host_port_properties (
	input wire logic       SYS_CLK_I,         // System clock.
	input wire logic       RST_I,             // Reset, active high.
	input wire logic       CS_N_I,            // Chip select.
	input wire logic       CMD_SEL_I,         // Command select.
	input wire logic       RD_N_I,            // Read strobe.
	input wire logic       WR_N_I,            // Write strobe.
	input wire logic [7:0] DATA_LINES_I,      // Bus in.
	input wire logic       DATA_LINES_OE_O,   // Bus drive enable.
	input wire logic       WAIT_N_O,          // Wait.
	input wire logic       DONE_O,            // Done.
	input wire logic       DONE_ACK_N_I,      // Done acknowledge.
	input wire logic       SERVICE_REQUEST_O, // Service request.
	input wire logic       SERVICE_ACK_N_I,   // Service acknowledge.
	input wire logic       FAULT_O,           // Fault.
	input wire logic       EXEC_DONE_I,       // Datapath finish.
	input wire logic [2:0] EXEC_ERR_I         // Datapath errors.
);
	// ==========================================================================
	// Helper state.
	logic wait_reg;
	logic svc_en_reg;
	logic stat_rd;

	// A status read is in progress while these three hold.
	assign stat_rd = !CS_N_I && CMD_SEL_I && !RD_N_I;

	// Keep the enable bit of the command byte seen when its write is acknowledged.
	always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			wait_reg   <= 1'b1;
			svc_en_reg <= 1'b0;
		end else begin
			wait_reg <= WAIT_N_O;
			if (WAIT_N_O && !wait_reg && !DATA_LINES_OE_O && CMD_SEL_I && !CS_N_I) begin
				svc_en_reg <= DATA_LINES_I[7];
			end
		end
	end

	// ==========================================================================
	// Assertions.
	reset_quiet_a: assert property (@(posedge SYS_CLK_I)
		RST_I |-> !DONE_O && !SERVICE_REQUEST_O && !FAULT_O && WAIT_N_O && !DATA_LINES_OE_O)
		else $error("outputs active during reset");
	deselect_wait_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		CS_N_I [*4] |=> WAIT_N_O)
		else $error("wait low while not selected");
	idle_wait_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		(!CS_N_I && RD_N_I && WR_N_I) [*5] |-> !WAIT_N_O)
		else $error("wait high while selected and idle");
	drive_wait_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		DATA_LINES_OE_O |-> WAIT_N_O)
		else $error("bus driven before wait released");
	done_set_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		EXEC_DONE_I |=> DONE_O)
		else $error("done not set at completion");
	done_ack_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		(!DONE_ACK_N_I [*3] ##0 !EXEC_DONE_I) |=> !DONE_O)
		else $error("done not cleared by acknowledge");
	svc_match_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		EXEC_DONE_I |=> SERVICE_REQUEST_O == svc_en_reg)
		else $error("service request differs from enable bit");
	svc_ack_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		(!SERVICE_ACK_N_I [*3] ##0 !EXEC_DONE_I) |=> !SERVICE_REQUEST_O)
		else $error("service request not cleared by acknowledge");
	fault_set_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		(EXEC_ERR_I != 3'h0) |=> FAULT_O)
		else $error("fault not raised on error");
	fault_hold_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		(FAULT_O && !stat_rd && !$past(stat_rd) && !$past(stat_rd, 2) && !$past(stat_rd, 3))
		|=> FAULT_O)
		else $error("fault cleared without status read");
endmodule

bind fhp_host_port fhp_host_port_properties chk_u (
	.SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .CS_N_I(CS_N_I), .CMD_SEL_I(CMD_SEL_I),
	.RD_N_I(RD_N_I), .WR_N_I(WR_N_I), .DATA_LINES_I(DATA_LINES_I),
	.DATA_LINES_OE_O(DATA_LINES_OE_O), .WAIT_N_O(WAIT_N_O), .DONE_O(DONE_O),
	.DONE_ACK_N_I(DONE_ACK_N_I), .SERVICE_REQUEST_O(SERVICE_REQUEST_O),
	.SERVICE_ACK_N_I(SERVICE_ACK_N_I), .FAULT_O(FAULT_O), .EXEC_DONE_I(EXEC_DONE_I),
	.EXEC_ERR_I(EXEC_ERR_I));

// [tb/fhp_host_port_tb.sv]
// Self-checking bench for the coprocessor host port.
`timescale 1ns/1ps
module fhp_host_port_tb;
	logic       clk       = 1'b0;
	logic       rst       = 1'b0;
	logic       cs_n      = 1'b1;
	logic       cmd_sel   = 1'b0;
	logic       rd_n      = 1'b1;
	logic       wr_n      = 1'b1;
	logic [7:0] din       = 8'h00;
	logic       dack_n    = 1'b1;
	logic       sack_n    = 1'b1;
	logic [7:0] lat       = 8'h08;
	logic [2:0] err_sel   = 3'h0;
	logic [7:0] cmds [3]  = '{8'h81, 8'h01, 8'h81};
	logic [7:0] dout;
	logic [7:0] rdat;
	logic [6:0] op;
	logic [2:0] xerr;
	logic       oe, wait_n, done, svc, fault, start, abort, xdone;
	int         error_cnt = 0;
	int         cmp_count = 0;
	int         cyc       = 0;
	int         n, t0, hi;

	// ==========================================================================
	// Clock, design and datapath model.
	always #12.5 clk = ~clk;

	fhp_host_port dut_u (.SYS_CLK_I(clk), .RST_I(rst), .CS_N_I(cs_n), .CMD_SEL_I(cmd_sel),
		.RD_N_I(rd_n), .WR_N_I(wr_n), .DATA_LINES_I(din), .DATA_LINES_O(dout),
		.DATA_LINES_OE_O(oe), .WAIT_N_O(wait_n), .DONE_O(done), .DONE_ACK_N_I(dack_n),
		.SERVICE_REQUEST_O(svc), .SERVICE_ACK_N_I(sack_n), .FAULT_O(fault),
		.EXEC_START_O(start), .EXEC_OP_O(op), .EXEC_ABORT_O(abort),
		.EXEC_DONE_I(xdone), .EXEC_ERR_I(xerr));

	fhp_exec_model exec_u (.clk_i(clk), .rst_i(rst), .start_i(start), .abort_i(abort),
		.lat_i(lat), .err_i(err_sel), .done_o(xdone), .err_o(xerr));

	// ==========================================================================
	// Tasks.
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Poll at falling edges so the registered outputs have settled.
	task automatic wait_for(input logic lvl);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (wait_n !== lvl && n < 400);
		if (n >= 400) check("wait level", {7'h00, lvl}, {7'h00, ~lvl});
	endtask

	// Strobe is held until wait rises; the next access waits for wait to drop.
	// The strobe falls only after wait has dropped, since an idle deselected port shows wait high.
	task automatic bus_wr(input logic sel, input logic [7:0] d);
		@(negedge clk);
		cs_n = 1'b0;
		cmd_sel = sel;
		din = d;
		wait_for(1'b0);
		wr_n = 1'b0;
		wait_for(1'b1);
		wr_n = 1'b1;
		wait_for(1'b0);
	endtask

	task automatic bus_rd(input logic sel, output logic [7:0] d);
		@(negedge clk);
		cs_n = 1'b0;
		cmd_sel = sel;
		wait_for(1'b0);
		rd_n = 1'b0;
		wait_for(1'b1);
		d = dout;
		check("bus drive", 8'h01, {7'h00, oe});
		rd_n = 1'b1;
		wait_for(1'b0);
	endtask

	task automatic wait_done();
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (done !== 1'b1 && n < 400);
		check("done", 8'h01, {7'h00, done});
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Cut a hang short well beyond the several hundred cycles the tests need.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			complete_run();
		end
	end

	// ==========================================================================
	// Test sequence.
	// Reset rises just after time zero so every register with an asynchronous reset sees its edge before the first clock.
	initial begin
		#1 rst = 1'b1;
		repeat (20) @(negedge clk);
		check("rst flags", 8'h00, {5'h00, done, svc, fault});
		rst = 1'b0;
		repeat (3) @(negedge clk);
		bus_rd(1'b1, rdat);
		check("status", 8'h00, rdat);
		cs_n = 1'b1;
		wr_n = 1'b0;
		repeat (6) @(negedge clk);
		check("wait off", 8'h01, {7'h00, wait_n});
		wr_n = 1'b1;
		repeat (4) @(negedge clk);
		cs_n = 1'b0;
		repeat (5) @(negedge clk);
		check("wait idle", 8'h00, {7'h00, wait_n});
		for (int k = 4; k <= 8; k += 4) begin
			for (int i = 0; i < k; i++) bus_wr(1'b0, 8'(k * 16 + i));
			for (int i = k - 1; i >= 0; i--) begin
				bus_rd(1'b0, rdat);
				check("pop", 8'(k * 16 + i), rdat);
			end
		end
		foreach (cmds[j]) begin
			bus_wr(1'b1, cmds[j]);
			wait_done();
			check("service", {7'h00, cmds[j][7]}, {7'h00, svc});
			check("opcode", {1'b0, cmds[j][6:0]}, {1'b0, op});
		end
		bus_rd(1'b1, rdat);
		check("done read", 8'h00, {7'h00, done});
		@(negedge clk);
		sack_n = 1'b0;
		repeat (4) @(negedge clk);
		check("service ack", 8'h00, {7'h00, svc});
		sack_n = 1'b1;
		lat = 8'h28;
		bus_wr(1'b1, 8'h02);
		bus_rd(1'b1, rdat);
		check("busy status", 8'h80, rdat);
		t0 = cyc;
		bus_wr(1'b0, 8'h5a);
		check("stretch", 8'h01, {7'h00, (cyc - t0) >= 20});
		check("done write", 8'h00, {7'h00, done});
		lat = 8'h0a;
		err_sel = 3'h1;
		bus_wr(1'b1, 8'h04);
		n = 0;
		while (fault !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		check("early fault", 8'h02, {6'h00, fault, done});
		err_sel = 3'h0;
		wait_done();
		bus_wr(1'b0, 8'h00);
		check("fault held", 8'h01, {7'h00, fault});
		bus_rd(1'b1, rdat);
		check("err status", 8'h01, rdat);
		repeat (3) @(negedge clk);
		check("fault clear", 8'h00, {7'h00, fault});
		dack_n = 1'b0;
		bus_wr(1'b1, 8'h01);
		hi = 0;
		repeat (40) begin
			@(negedge clk);
			hi += done;
		end
		check("done pulse", 8'h01, 8'(hi));
		dack_n = 1'b1;
		lat = 8'h3c;
		bus_wr(1'b1, 8'h81);
		repeat (5) @(negedge clk);
		rst = 1'b1;
		repeat (5) @(negedge clk);
		check("abort", 8'h01, {7'h00, abort});
		rst = 1'b0;
		repeat (80) @(negedge clk);
		check("no finish", 8'h00, {6'h00, done, svc});
		bus_rd(1'b1, rdat);
		check("status rst", 8'h00, rdat);
		complete_run();
	end
endmodule
